// File: logic/branch_decode_consts.vh
`ifndef BRANCH_DECODE_CONSTS_VH
`define BRANCH_DECODE_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_MASK 5'h08
`define OFS_STATE 5'h0C
`define OFS_RET 5'h10
`define OFS_COUNT 5'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'h1
`define MASK_RESET 5'h00
`define EV_REDIRECT 0
`define EV_ILLEGAL 1
`define EV_TRAP 2
`define EV_SLEEP 3
`define EV_EXC_RET 4
`define EV_W 5
`define ST_T_BIT 0
`define ST_S_BIT 1
`define ST_SLEEP_BIT 2
`define ST_SLOT_BIT 3

// ----------------------------------------------------------------
// Instruction groups (bits 15:12)
// ----------------------------------------------------------------
`define GRP_LDB 4'h4
`define GRP_LDW 4'h5
`define GRP_LDL 4'h6
`define GRP_BRANCH 4'hA
`define GRP_SYS 4'hB

// ----------------------------------------------------------------
// Branch group operations (bits 11:8)
// ----------------------------------------------------------------
`define BR_IF_FALSE 4'h0
`define BR_IF_FALSE_D 4'h1
`define BR_IF_TRUE 4'h2
`define BR_IF_TRUE_D 4'h3
`define BR_JUMP_REL 4'h4
`define BR_CALL_REL 4'h5
`define BR_JUMP_REG_REL 4'h6
`define BR_CALL_REG_REL 4'h7
`define BR_JUMP_ABS 4'h8
`define BR_CALL_ABS 4'h9
`define BR_CALL_RETURN 4'hA

// ----------------------------------------------------------------
// System group operations (bits 11:8)
// ----------------------------------------------------------------
`define SY_T_CLEAR 4'h0
`define SY_T_SET 4'h1
`define SY_S_CLEAR 4'h2
`define SY_S_SET 4'h3
`define SY_ACC_CLEAR 4'h4
`define SY_LOAD_CTL 4'h5
`define SY_STORE_CTL 4'h6
`define SY_LOAD_SYS 4'h7
`define SY_STORE_SYS 4'h8
`define SY_LOAD_TLB 4'h9
`define SY_NOP 4'hA
`define SY_CACHE_WARM 4'hB
`define SY_EXC_RETURN 4'hC
`define SY_POWER_DOWN 4'hD
`define SY_TRAP 4'hE

// ----------------------------------------------------------------
// Minimum execution cycles with no wait states
// ----------------------------------------------------------------
`define CYC_BASE 3'd1
`define CYC_TAKEN 3'd2
`define CYC_EXC_RET 3'd4
`define CYC_SLEEP 3'd3
`define CYC_TRAP 3'd6
`define PC_STEP 32'h00000004

`endif

// File: logic/branch_decode.v
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`include "branch_decode_consts.vh"

module branch_decode (
	input wire ref_clk,
	input wire rst_b,
	input wire fetch_valid,
	input wire [15:0] fetch_instr,
	input wire [31:0] fetch_pc,
	output reg fetch_ready,
	input wire priv_mode,
	input wire mem_wait,
	input wire mem_contend,
	input wire wake,
	input wire alu_t_valid,
	input wire alu_t_value,
	input wire [31:0] exc_saved_pc,
	input wire exc_saved_t,
	output reg exe_valid,
	output reg [15:0] exe_instr,
	output reg [31:0] exe_pc,
	output reg [3:0] exe_src_sel,
	output reg [3:0] exe_dst_sel,
	output reg exe_gpr_we,
	output reg exe_priv,
	output reg exe_load,
	output reg [5:0] exe_ld_offset,
	output reg exe_delay_slot,
	output reg move_valid,
	output reg move_into_special,
	output reg move_is_system,
	output reg [3:0] move_sel,
	output reg redirect_valid,
	output reg [31:0] redirect_pc,
	output reg redirect_use_reg,
	output reg [3:0] redirect_reg_sel,
	output reg exc_return,
	output reg illegal_exc,
	output reg trap_req,
	output reg [7:0] trap_imm,
	output reg tlb_load,
	output reg prefetch_req,
	output reg acc_clear,
	output reg sleep_active,
	output reg t_flag,
	output reg s_flag,
	output reg irq,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg avs_waitrequest,
	output reg [31:0] avs_readdata
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function is_priv;
		input [15:0] w;
		begin
			is_priv = (w[15:12] == `GRP_SYS) &&
				(w[11:8] == `SY_LOAD_CTL || w[11:8] == `SY_STORE_CTL ||
				w[11:8] == `SY_LOAD_TLB || w[11:8] == `SY_EXC_RETURN ||
				w[11:8] == `SY_POWER_DOWN);
		end
	endfunction

	function is_load;
		input [15:0] w;
		begin
			is_load = (w[15:12] == `GRP_LDB) || (w[15:12] == `GRP_LDW) ||
				(w[15:12] == `GRP_LDL);
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg ctrl_en_r;
	reg [`EV_W-1:0] status_r;
	reg [`EV_W-1:0] mask_r;
	reg [31:0] ret_addr_r;
	reg [31:0] count_r;
	reg hold_v_r;
	reg [15:0] hold_w_r;
	reg [31:0] hold_pc_r;
	reg ld_pend_r;
	reg [3:0] ld_dst_r;
	reg slot_pend_r;
	reg [31:0] slot_pc_r;
	reg slot_use_reg_r;
	reg [3:0] slot_reg_r;
	reg [2:0] busy_r;

	wire accept = fetch_valid & fetch_ready;
	wire go = hold_v_r | accept;
	wire [15:0] cw = hold_v_r ? hold_w_r : fetch_instr;
	wire [31:0] cpc = hold_v_r ? hold_pc_r : fetch_pc;
	wire [3:0] grp = cw[15:12];
	wire [3:0] op = cw[11:8];
	wire hazard = ld_pend_r & ((cw[11:8] == ld_dst_r) | (cw[7:4] == ld_dst_r));
	wire issue = go & ~mem_wait & ~mem_contend & ~hazard;
	wire [31:0] disp_x2 = {{23{cw[7]}}, cw[7:0], 1'b0};
	wire [31:0] next_pc = cpc + `PC_STEP;

	// ----------------------------------------------------------------
	// Combinational decode of the word being issued
	// ----------------------------------------------------------------
	reg d_known;
	reg d_branch;
	reg d_taken;
	reg d_delayed;
	reg d_call;
	reg d_use_reg;
	reg [31:0] d_target;
	reg d_gpr_we;
	reg [2:0] d_cyc;
	reg d_illegal;
	reg [5:0] d_offset;

	always @* begin
		d_known = 1'b1;
		d_branch = 1'b0;
		d_taken = 1'b0;
		d_delayed = 1'b0;
		d_call = 1'b0;
		d_use_reg = 1'b0;
		d_target = next_pc + disp_x2;
		d_gpr_we = 1'b0;
		d_cyc = `CYC_BASE;
		d_offset = 6'h00;
		case (grp)
			`GRP_LDB: begin
				d_gpr_we = 1'b1;
				d_offset = {2'b00, cw[3:0]};
			end
			`GRP_LDW: begin
				d_gpr_we = 1'b1;
				d_offset = {1'b0, cw[3:0], 1'b0};
			end
			`GRP_LDL: begin
				d_gpr_we = 1'b1;
				d_offset = {cw[3:0], 2'b00};
			end
			`GRP_BRANCH: begin
				d_branch = 1'b1;
				case (op)
					`BR_IF_FALSE, `BR_IF_FALSE_D: begin
						d_taken = ~t_flag;
						d_delayed = (op == `BR_IF_FALSE_D);
					end
					`BR_IF_TRUE, `BR_IF_TRUE_D: begin
						d_taken = t_flag;
						d_delayed = (op == `BR_IF_TRUE_D);
					end
					`BR_JUMP_REL, `BR_CALL_REL: begin
						d_taken = 1'b1;
						d_delayed = 1'b1;
						d_call = (op == `BR_CALL_REL);
					end
					`BR_JUMP_REG_REL, `BR_CALL_REG_REL: begin
						d_taken = 1'b1;
						d_delayed = 1'b1;
						d_use_reg = 1'b1;
						d_target = next_pc;
						d_call = (op == `BR_CALL_REG_REL);
					end
					`BR_JUMP_ABS, `BR_CALL_ABS: begin
						d_taken = 1'b1;
						d_delayed = 1'b1;
						d_use_reg = 1'b1;
						d_target = 32'h00000000;
						d_call = (op == `BR_CALL_ABS);
					end
					`BR_CALL_RETURN: begin
						d_taken = 1'b1;
						d_target = ret_addr_r;
					end
					default: d_known = 1'b0;
				endcase
				if (d_taken)
					d_cyc = `CYC_TAKEN;
			end
			`GRP_SYS: begin
				case (op)
					`SY_STORE_CTL, `SY_STORE_SYS: d_gpr_we = 1'b1;
					`SY_EXC_RETURN: begin
						d_target = exc_saved_pc;
						d_cyc = `CYC_EXC_RET;
					end
					`SY_POWER_DOWN: d_cyc = `CYC_SLEEP;
					`SY_TRAP: d_cyc = `CYC_TRAP;
					`SY_T_CLEAR, `SY_T_SET, `SY_S_CLEAR, `SY_S_SET, `SY_ACC_CLEAR,
					`SY_LOAD_CTL, `SY_LOAD_SYS, `SY_LOAD_TLB, `SY_NOP,
					`SY_CACHE_WARM: d_gpr_we = 1'b0;
					default: d_known = 1'b0;
				endcase
			end
			default: d_gpr_we = 1'b1;
		endcase
		// Unknown code, privilege fault or a branch sitting in a delay slot
		d_illegal = ~d_known | (is_priv(cw) & ~priv_mode) | (slot_pend_r & d_branch);
	end

	wire ok = issue & ~d_illegal;
	wire is_sys = (grp == `GRP_SYS);
	wire do_exc_ret = ok & is_sys & (op == `SY_EXC_RETURN);
	wire do_sleep = ok & is_sys & (op == `SY_POWER_DOWN);
	wire do_trap = ok & is_sys & (op == `SY_TRAP);
	wire now_redirect = ok & ((d_taken & ~d_delayed) | do_exc_ret);
	wire slot_fire = ok & slot_pend_r;
	wire [2:0] busy_nxt = (issue & ~d_illegal) ? d_cyc - 3'd1 :
		(busy_r != 3'd0 ? busy_r - 3'd1 : 3'd0);
	wire sleep_nxt = do_sleep | (sleep_active & ~wake);
	wire hold_nxt = go & ~issue;
	wire [`EV_W-1:0] events = {do_exc_ret, do_sleep, do_trap, issue & d_illegal,
		now_redirect | slot_fire};

	// ----------------------------------------------------------------
	// Issue stage
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fetch_ready <= 1'b0;
			hold_v_r <= 1'b0;
			hold_w_r <= 16'h0000;
			hold_pc_r <= 32'h00000000;
			ld_pend_r <= 1'b0;
			ld_dst_r <= 4'h0;
			slot_pend_r <= 1'b0;
			slot_pc_r <= 32'h00000000;
			slot_use_reg_r <= 1'b0;
			slot_reg_r <= 4'h0;
			busy_r <= 3'd0;
			ret_addr_r <= 32'h00000000;
			count_r <= 32'h00000000;
			exe_valid <= 1'b0;
			exe_instr <= 16'h0000;
			exe_pc <= 32'h00000000;
			exe_src_sel <= 4'h0;
			exe_dst_sel <= 4'h0;
			exe_gpr_we <= 1'b0;
			exe_priv <= 1'b0;
			exe_load <= 1'b0;
			exe_ld_offset <= 6'h00;
			exe_delay_slot <= 1'b0;
			move_valid <= 1'b0;
			move_into_special <= 1'b0;
			move_is_system <= 1'b0;
			move_sel <= 4'h0;
			redirect_valid <= 1'b0;
			redirect_pc <= 32'h00000000;
			redirect_use_reg <= 1'b0;
			redirect_reg_sel <= 4'h0;
			exc_return <= 1'b0;
			illegal_exc <= 1'b0;
			trap_req <= 1'b0;
			trap_imm <= 8'h00;
			tlb_load <= 1'b0;
			prefetch_req <= 1'b0;
			acc_clear <= 1'b0;
			sleep_active <= 1'b0;
			t_flag <= 1'b0;
			s_flag <= 1'b0;
		end else begin
			hold_v_r <= hold_nxt;
			if (accept) begin
				hold_w_r <= fetch_instr;
				hold_pc_r <= fetch_pc;
			end
			busy_r <= busy_nxt;
			sleep_active <= sleep_nxt;
			fetch_ready <= ctrl_en_r & ~hold_nxt & (busy_nxt == 3'd0) & ~sleep_nxt;
			ld_pend_r <= ok & is_load(cw);
			if (ok & is_load(cw))
				ld_dst_r <= cw[11:8];
			exe_valid <= ok;
			exe_instr <= cw;
			exe_pc <= cpc;
			exe_dst_sel <= cw[11:8];
			exe_src_sel <= cw[7:4];
			exe_gpr_we <= ok & d_gpr_we;
			exe_priv <= is_priv(cw);
			exe_load <= ok & is_load(cw);
			exe_ld_offset <= d_offset;
			exe_delay_slot <= slot_fire;
			move_valid <= ok & is_sys & (op >= `SY_LOAD_CTL) & (op <= `SY_STORE_SYS);
			move_into_special <= (op == `SY_LOAD_CTL) | (op == `SY_LOAD_SYS);
			move_is_system <= (op == `SY_LOAD_SYS) | (op == `SY_STORE_SYS);
			move_sel <= cw[3:0];
			exc_return <= do_exc_ret;
			illegal_exc <= issue & d_illegal;
			trap_req <= do_trap;
			trap_imm <= cw[7:0];
			tlb_load <= ok & is_sys & (op == `SY_LOAD_TLB);
			prefetch_req <= ok & is_sys & (op == `SY_CACHE_WARM);
			acc_clear <= ok & is_sys & (op == `SY_ACC_CLEAR);
			if (ok & d_call)
				ret_addr_r <= next_pc;
			if (ok)
				count_r <= count_r + 32'h00000001;
			// Delayed transfer waits for the slot instruction to issue
			if (slot_fire) begin
				slot_pend_r <= 1'b0;
				redirect_valid <= 1'b1;
				redirect_pc <= slot_pc_r;
				redirect_use_reg <= slot_use_reg_r;
				redirect_reg_sel <= slot_reg_r;
			end else begin
				if (issue & d_illegal)
					slot_pend_r <= 1'b0;
				else if (ok & d_taken & d_delayed)
					slot_pend_r <= 1'b1;
				if (ok & d_taken & d_delayed) begin
					slot_pc_r <= d_target;
					slot_use_reg_r <= d_use_reg;
					slot_reg_r <= cw[7:4];
				end
				redirect_valid <= now_redirect;
				redirect_pc <= d_target;
				redirect_use_reg <= 1'b0;
				redirect_reg_sel <= cw[7:4];
			end
			// Issued instruction is newer than the ALU result, so it wins
			if (do_exc_ret)
				t_flag <= exc_saved_t;
			else if (ok & is_sys & (op == `SY_T_CLEAR))
				t_flag <= 1'b0;
			else if (ok & is_sys & (op == `SY_T_SET))
				t_flag <= 1'b1;
			else if (alu_t_valid)
				t_flag <= alu_t_value;
			if (ok & is_sys & (op == `SY_S_CLEAR))
				s_flag <= 1'b0;
			else if (ok & is_sys & (op == `SY_S_SET))
				s_flag <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait cycle on every access
	// ----------------------------------------------------------------
	wire req = avs_read | avs_write;
	wire ack = req & ~avs_waitrequest;
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h00000000;
		case (avs_address)
			`OFS_CTRL: rd_mux = {31'h00000000, ctrl_en_r};
			`OFS_STATUS: rd_mux = {27'h0000000, status_r};
			`OFS_MASK: rd_mux = {27'h0000000, mask_r};
			`OFS_STATE: rd_mux = {28'h0000000, slot_pend_r, sleep_active, s_flag, t_flag};
			`OFS_RET: rd_mux = ret_addr_r;
			`OFS_COUNT: rd_mux = count_r;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			ctrl_en_r <= `CTRL_RESET;
			mask_r <= `MASK_RESET;
			status_r <= {`EV_W{1'b0}};
			irq <= 1'b0;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (req & avs_waitrequest)
				avs_readdata <= avs_read ? rd_mux : 32'h00000000;
			if (ack & avs_write & avs_byteenable[0]) begin
				if (avs_address == `OFS_CTRL)
					ctrl_en_r <= avs_writedata[`CTRL_EN_BIT];
				if (avs_address == `OFS_MASK)
					mask_r <= avs_writedata[`EV_W-1:0];
			end
			// Only bits already returned are cleared; new events still set
			if (ack & avs_read & (avs_address == `OFS_STATUS))
				status_r <= (status_r & ~avs_readdata[`EV_W-1:0]) | events;
			else
				status_r <= status_r | events;
			irq <= |((status_r | events) & mask_r);
		end
	end

endmodule // branch_decode

// File: tb/branch_decode_props.sv
`include "branch_decode_consts.vh"
module branch_decode_props (
	input wire ref_clk,
	input wire rst_b,
	input wire fetch_ready,
	input wire mem_wait,
	input wire mem_contend,
	input wire exe_valid,
	input wire [15:0] exe_instr,
	input wire [3:0] exe_src_sel,
	input wire [3:0] exe_dst_sel,
	input wire exe_gpr_we,
	input wire exe_priv,
	input wire exe_load,
	input wire [5:0] exe_ld_offset,
	input wire move_valid,
	input wire move_into_special,
	input wire illegal_exc,
	input wire prefetch_req,
	input wire sleep_active,
	input wire t_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Decode views
	// ----
	wire [3:0] op = exe_instr[11:8];
	wire [3:0] grp = exe_instr[15:12];
	wire sys = exe_valid && grp == `GRP_SYS;
	wire pop = op == `SY_LOAD_CTL || op == `SY_STORE_CTL || op == `SY_LOAD_TLB ||
		op == `SY_EXC_RETURN || op == `SY_POWER_DOWN;
	wire [5:0] sc = grp == `GRP_LDB ? {2'h0, exe_instr[3:0]} :
		grp == `GRP_LDW ? {1'h0, exe_instr[3:0], 1'h0} : {exe_instr[3:0], 2'h0};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence load_issue;
		exe_valid && exe_load;
	endsequence
	a_sel_map: assert property (exe_valid |-> exe_dst_sel == op &&
		exe_src_sel == exe_instr[7:4]) else $error("selector mismatch");
	a_priv_class: assert property (sys |-> exe_priv == pop)
		else $error("privilege class wrong");
	a_illegal_quiet: assert property (illegal_exc |-> !exe_valid && !move_valid)
		else $error("illegal word issued");
	a_load_move: assert property (sys && (op == `SY_LOAD_CTL || op == `SY_LOAD_SYS)
		|-> move_valid && move_into_special) else $error("load move missing");
	a_warm_nowrite: assert property (prefetch_req |-> !exe_gpr_we)
		else $error("prefetch writes register");
	a_offset_scale: assert property (exe_valid && exe_load |-> exe_ld_offset == sc)
		else $error("offset scaling wrong");
	a_load_use: assert property (load_issue ##1 exe_valid |->
		exe_dst_sel != $past(exe_dst_sel) && exe_src_sel != $past(exe_dst_sel))
		else $error("load use not stalled");
	a_sleep_hold: assert property (sleep_active && $past(sleep_active) |-> !exe_valid)
		else $error("issue while asleep");
	a_wait_stall: assert property (mem_wait |=> !exe_valid)
		else $error("issue during wait");
	a_contend_stall: assert property (mem_contend |=> !exe_valid)
		else $error("issue during contention");
	a_t_set: assert property (sys && op == `SY_T_SET |-> ##[0:1] t_flag)
		else $error("test flag not set");
endmodule // branch_decode_props
bind branch_decode branch_decode_props u_props (.ref_clk, .rst_b, .fetch_ready, .mem_wait,
	.mem_contend, .exe_valid, .exe_instr, .exe_src_sel, .exe_dst_sel, .exe_gpr_we, .exe_priv,
	.exe_load, .exe_ld_offset, .move_valid, .move_into_special, .illegal_exc, .prefetch_req,
	.sleep_active, .t_flag);

// File: tb/fetch_model.sv
module fetch_model (
	input wire ref_clk,
	input wire fetch_ready,
	output logic fetch_valid,
	output logic [15:0] fetch_instr,
	output logic [31:0] fetch_pc
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		fetch_valid = 1'h0;
		fetch_instr = 16'h0000;
		fetch_pc = 32'h0;
	end
	// Holds the word until taken; leaves valid high for back-to-back words
	task automatic send(input logic [15:0] w, input logic [31:0] pc);
		fetch_valid <= 1'h1;
		fetch_instr <= w;
		fetch_pc <= pc;
		@(posedge ref_clk);
		while (fetch_ready !== 1'h1) @(posedge ref_clk);
	endtask
	// Released lines show the inverse so stale words cannot pass
	task automatic idle;
		fetch_valid <= 1'h0;
		fetch_instr <= ~fetch_instr;
		fetch_pc <= ~fetch_pc;
	endtask
endmodule // fetch_model

// File: tb/tb_branch_decode.sv
`include "branch_decode_consts.vh"
module tb_branch_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'h0, rst_b = 1'h0, priv_mode = 1'h1, mem_wait = 1'h0, mem_contend = 1'h0;
	logic wake = 1'h0, xt = 1'h1, avs_read = 1'h0, avs_write = 1'h0, alu_v = 1'h0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, pc_now = 32'h100, red_pc = 32'h0;
	wire fetch_valid, fetch_ready, exe_valid, exe_delay_slot, move_valid, redirect_valid;
	wire exc_return, illegal_exc, sleep_active, t_flag, irq, avs_waitrequest, prefetch_req;
	wire [15:0] fetch_instr;
	wire [31:0] fetch_pc, redirect_pc, avs_readdata;
	int errors = 0, check_count = 0, cyc = 0, t_exe = 0, n_exe = 0, n_red = 0, n_ill = 0;
	int n_mov = 0, n_slot = 0, n_xr = 0, n_pf = 0;
	int gaps[$];
	always #50 ref_clk = ~ref_clk;
	fetch_model fu (.ref_clk, .fetch_ready, .fetch_valid, .fetch_instr, .fetch_pc);
	branch_decode uut (.ref_clk, .rst_b, .fetch_valid, .fetch_instr, .fetch_pc, .fetch_ready,
		.priv_mode, .mem_wait, .mem_contend, .wake, .alu_t_valid(alu_v), .alu_t_value(1'h0),
		.exc_saved_pc(32'h200), .exc_saved_t(xt), .exe_valid, .exe_instr(), .exe_pc(),
		.exe_src_sel(), .exe_dst_sel(), .exe_gpr_we(), .exe_priv(), .exe_load(),
		.exe_ld_offset(), .exe_delay_slot, .move_valid, .move_into_special(),
		.move_is_system(), .move_sel(), .redirect_valid, .redirect_pc,
		.redirect_use_reg(), .redirect_reg_sel(), .exc_return, .illegal_exc, .trap_req(),
		.trap_imm(), .tlb_load(), .prefetch_req, .acc_clear(), .sleep_active, .t_flag,
		.s_flag(), .irq, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_waitrequest, .avs_readdata);
	// ----
	// Pulse monitor and timeout
	// ----
	always @(posedge ref_clk) begin
		cyc++;
		if (exe_valid === 1'h1) begin
			gaps.push_back(cyc - t_exe);
			t_exe = cyc;
			n_exe++;
		end
		n_slot += (exe_valid === 1'h1 && exe_delay_slot === 1'h1);
		n_red += (redirect_valid === 1'h1);
		n_ill += (illegal_exc === 1'h1);
		n_mov += (move_valid === 1'h1);
		n_xr += (exc_return === 1'h1);
		n_pf += (prefetch_req === 1'h1);
		if (redirect_valid === 1'h1)
			red_pc = redirect_pc;
		if (cyc > 20000) begin
			errors++;
			give_verdict;
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'h0) @(posedge ref_clk);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic issue(input logic [15:0] w);
		int e0;
		e0 = n_exe + n_ill;
		pc_now += 32'h4;
		fu.send(w, pc_now);
		fu.idle;
		for (int k = 0; k < 20 && n_exe + n_ill == e0; k++) @(posedge ref_clk);
		@(posedge ref_clk);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		logic [31:0] q;
		bus(1'h0, `OFS_CTRL, 32'h0, q);
		check("ctrl", q, 32'h1);
		bus(1'h0, `OFS_MASK, 32'h0, q);
		check("mask", q, 32'h0);
		bus(1'h1, 5'h1C, 32'hFFFFFFFF, q);
		bus(1'h0, 5'h1C, 32'h0, q);
		check("unmapped", q, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_branch;
		int r0, s0;
		logic tk;
		for (int tv = 0; tv < 2; tv++) begin
			issue({`GRP_SYS, tv[0] ? `SY_T_SET : `SY_T_CLEAR, 8'h00});
			check("t flag", t_flag, tv);
			for (int op = 0; op < 4; op++) begin
				r0 = n_red;
				s0 = n_slot;
				tk = op[1] ? tv[0] : !tv[0];
				issue({`GRP_BRANCH, op[3:0], 8'h04});
				if (op[0])
					issue({`GRP_SYS, `SY_NOP, 8'h00});
				check("redirect", n_red - r0, tk);
				if (op[0] && tk)
					check("slot", n_slot - s0, 1);
			end
		end
		$display("t_branch done");
	endtask
	task automatic t_call;
		logic [3:0] ops [3] = '{`BR_CALL_REL, `BR_CALL_REG_REL, `BR_CALL_ABS};
		logic [31:0] cpc;
		for (int i = 0; i < 3; i++) begin
			issue({`GRP_BRANCH, ops[i], 8'h10});
			cpc = pc_now;
			issue({`GRP_SYS, `SY_NOP, 8'h00});
			issue({`GRP_BRANCH, `BR_CALL_RETURN, 8'h00});
			check("return pc", red_pc, cpc + 32'h4);
		end
		$display("t_call done");
	endtask
	task automatic t_priv;
		logic [3:0] ops [4] = '{`SY_LOAD_CTL, `SY_STORE_CTL, `SY_LOAD_SYS, `SY_STORE_SYS};
		int i0, m0, f0;
		for (int p = 0; p < 2; p++) begin
			priv_mode <= p[0];
			for (int i = 0; i < 4; i++) begin
				i0 = n_ill;
				m0 = n_mov;
				issue({`GRP_SYS, ops[i], 8'h35});
				check("illegal", n_ill - i0, p == 0 && i < 2);
				check("move", n_mov - m0, !(p == 0 && i < 2));
			end
		end
		f0 = n_pf;
		issue({`GRP_SYS, `SY_CACHE_WARM, 8'h00});
		check("prefetch", n_pf - f0, 1);
		issue({`GRP_SYS, `SY_TRAP, 8'h07});
		issue({`GRP_SYS, `SY_S_SET, 8'h00});
		alu_v <= 1'h1;
		@(posedge ref_clk);
		alu_v <= 1'h0;
		@(posedge ref_clk);
		check("alu t", t_flag, 0);
		issue({`GRP_SYS, `SY_T_CLEAR, 8'h00});
		i0 = n_xr;
		issue({`GRP_SYS, `SY_EXC_RETURN, 8'h00});
		check("exc return", n_xr - i0, 1);
		check("exc target", red_pc, 32'h200);
		check("t restored", t_flag, xt);
		$display("t_priv done");
	endtask
	task automatic t_load;
		for (int g = 4; g < 7; g++) begin
			gaps.delete();
			fu.send({g[3:0], 12'h312}, 32'h400);
			fu.send({`GRP_SYS, `SY_NOP, 8'h00}, 32'h404);
			fu.send({g[3:0], 12'h312}, 32'h408);
			fu.send({`GRP_SYS, `SY_NOP, 8'h30}, 32'h40C);
			fu.send({`GRP_SYS, `SY_NOP, 8'h00}, 32'h410);
			fu.idle;
			for (int k = 0; k < 16 && gaps.size() < 5; k++) @(posedge ref_clk);
			check("indep gap", gaps[1], 1);
			check("load gap", gaps[3], 2);
			check("free gap", gaps[4], 1);
		end
		$display("t_load done");
	endtask
	task automatic t_stall;
		int e0;
		e0 = n_exe;
		mem_wait <= 1'h1;
		mem_contend <= 1'h1;
		@(posedge ref_clk);
		fork
			issue({`GRP_SYS, `SY_NOP, 8'h00});
		join_none
		repeat (6) @(posedge ref_clk);
		check("stalled", n_exe - e0, 0);
		mem_wait <= 1'h0;
		mem_contend <= 1'h0;
		wait fork;
		check("resumed", n_exe - e0, 1);
		$display("t_stall done");
	endtask
	task automatic t_sleep;
		issue({`GRP_SYS, `SY_POWER_DOWN, 8'h00});
		check("asleep", sleep_active, 1);
		check("ready asleep", fetch_ready, 0);
		wake <= 1'h1;
		for (int k = 0; k < 20 && sleep_active !== 1'h0; k++) @(posedge ref_clk);
		wake <= 1'h0;
		check("awake", sleep_active, 0);
		$display("t_sleep done");
	endtask
	task automatic t_irq;
		logic [31:0] q;
		priv_mode <= 1'h0;
		issue({`GRP_SYS, `SY_LOAD_CTL, 8'h00});
		repeat (2) @(posedge ref_clk);
		check("irq masked", irq, 0);
		bus(1'h1, `OFS_MASK, 32'h2, q);
		for (int k = 0; k < 5 && irq !== 1'h1; k++) @(posedge ref_clk);
		check("irq raised", irq, 1);
		bus(1'h0, `OFS_STATUS, 32'h0, q);
		check("status", q[1], 1);
		check("trap status", q[2], 1);
		@(posedge ref_clk);
		check("irq cleared", irq, 0);
		bus(1'h0, `OFS_STATUS, 32'h0, q);
		check("status clear", q[1], 0);
		bus(1'h0, `OFS_STATE, 32'h0, q);
		check("s flag", q[1], 1);
		$display("t_irq done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge ref_clk);
		t_regs;
		t_branch;
		t_call;
		t_priv;
		t_load;
		t_stall;
		t_sleep;
		t_irq;
		give_verdict;
	end
endmodule // tb_branch_decode
